// File: core/lrdbc_pkg.sv
package lrdbc_pkg;
  // Link shape: 8 lines, 6 data bits plus one balance slot per frame
  localparam int LINES      = 8;
  localparam int DATA_BITS  = 6;
  localparam int SLOTS      = 7;
  localparam int WORD_W     = LINES * DATA_BITS;
  localparam int BAL_SLOT   = 6;
  localparam int FIFO_DEPTH = 8;

  // Serialiser timing, in system clock cycles at 250 MHz
  localparam int CLOCK_MHZ      = 250;
  localparam int BIT_DIV        = 4;
  localparam int DIV_W          = 2;
  localparam int CLK_HIGH_SLOTS = 4;
  localparam int FRAME_CYCLES   = SLOTS * BIT_DIV;
  localparam int SAMPLE_PHASE   = BIT_DIV / 2;
  localparam int PCLK_HALF      = FRAME_CYCLES / 2;
  localparam int CLK_LOSS       = 2 * FRAME_CYCLES;

  // Deskew: restart needs a low pulse longer than this many link clocks
  localparam int DESKEW_MIN_LOW = 4;
  localparam int CAL_FRAMES     = 4096;
  localparam int CAL_W          = 13;

  // Running disparity saturation bounds
  localparam logic signed [4:0] RD_MAX   = 5'sh07;
  localparam logic signed [4:0] RD_MIN   = -5'sh06;
  localparam logic signed [4:0] RD_RESET = 5'sh00;
endpackage

// File: core/lrdbc_link_if.sv
`timescale 1ns/1ps
// Differential link between serializer end and receiver end
interface lrdbc_link_if;
  logic [lrdbc_pkg::LINES-1:0] linkDataInPos;
  logic [lrdbc_pkg::LINES-1:0] linkDataInNeg;
  logic                        linkClockInPos;
  logic                        linkClockInNeg;

  modport tx (
    output linkDataInPos,
    output linkDataInNeg,
    output linkClockInPos,
    output linkClockInNeg
  );
  modport rx (
    input linkDataInPos,
    input linkDataInNeg,
    input linkClockInPos,
    input linkClockInNeg
  );
endinterface

// File: core/lrdbc_fifo.sv
`timescale 1ns/1ps
module lrdbc_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wrPtr_q;
  logic [PW:0]      rdPtr_q;
  wire              push;
  wire              pop;

  // Full when pointers differ only in the wrap bit
  assign inReady  = (wrPtr_q ^ rdPtr_q) != {1'b1, {PW{1'b0}}};
  assign outValid = wrPtr_q != rdPtr_q;
  assign outData  = mem[rdPtr_q[PW-1:0]];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  // Storage has no reset; only pointers matter
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q[PW-1:0]] <= inData;
    end
  end

  // Pointer update
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule

// File: core/lrdbc_tx.sv
`timescale 1ns/1ps
module lrdbc_tx (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  input  wire logic [lrdbc_pkg::WORD_W-1:0] sourceData,
  input  wire logic                        sourceValid,
  output logic                             sourceReady,
  input  wire logic                        balanceSelect,
  input  wire logic                        dataFloat,
  input  wire logic                        clockFloat,
  lrdbc_link_if.tx                         link
);
  import lrdbc_pkg::*;

  logic [DIV_W-1:0]     divCnt_q;
  logic [2:0]           slot_q;
  logic [SLOTS-1:0]     bits_q [LINES];
  logic signed [4:0]    rd_q [LINES];
  logic [SLOTS-1:0]     bits_d [LINES];
  logic signed [4:0]    rd_d [LINES];
  logic [LINES-1:0]     dataPos_q;
  logic [LINES-1:0]     dataNeg_q;
  logic                 clkPos_q;
  logic                 clkNeg_q;
  logic [WORD_W-1:0]    headData;
  logic                 headValid;
  wire                  tick;
  wire                  frameStart;
  wire  [WORD_W-1:0]    word;

  // Word disparity: ones minus zeros over six bits
  function automatic logic signed [4:0] disparityOf(input logic [5:0] w);
    logic [2:0] ones;
    ones = 3'h0;
    for (int i = 0; i < DATA_BITS; i++) begin
      ones = ones + {2'h0, w[i]};
    end
    return $signed({1'b0, ones, 1'b0}) - 5'sh06;
  endfunction

  // Buffer absorbs bursts; source stalls when it fills
  lrdbc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) wordFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inData   (sourceData),
    .inValid  (sourceValid),
    .inReady  (sourceReady),
    .outData  (headData),
    .outValid (headValid),
    .outReady (frameStart)
  );

  // Bit and frame timing from the divider
  assign tick       = divCnt_q == DIV_W'(BIT_DIV - 1);
  assign frameStart = tick && slot_q == 3'(SLOTS - 1);
  assign word       = headValid ? headData : '0;

  // Per-line balance encoder
  always_comb begin
    logic [5:0]        w;
    logic signed [4:0] dd;
    logic signed [4:0] sum;
    logic              inv;
    w   = '0;
    dd  = '0;
    sum = '0;
    inv = 1'b0;
    for (int l = 0; l < LINES; l++) begin
      w  = word[l*DATA_BITS +: DATA_BITS];
      dd = disparityOf(w);
      if (rd_q[l] == 5'sh00) inv = 1'b1;
      else if (rd_q[l] > 5'sh00) inv = dd > 5'sh00;
      else inv = dd <= 5'sh00;
      inv = inv & balanceSelect;
      // Invert keeps rd + 1 - dd, plain keeps rd + dd - 1
      sum = inv ? rd_q[l] + 5'sh01 - dd : rd_q[l] + dd - 5'sh01;
      if (!balanceSelect) rd_d[l] = rd_q[l];
      else if (sum > RD_MAX) rd_d[l] = RD_MAX;
      else if (sum < RD_MIN) rd_d[l] = RD_MIN;
      else rd_d[l] = sum;
      // Balance slot carries the inversion flag
      bits_d[l] = {inv, w ^ {DATA_BITS{inv}}};
    end
  end

  // Divider, slot counter and frame load
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      divCnt_q <= '0;
      // Start in the balance slot so the first edge carries an encoded word
      slot_q   <= 3'(SLOTS - 1);
      for (int l = 0; l < LINES; l++) begin
        bits_q[l] <= '0;
        rd_q[l]   <= RD_RESET;
      end
    end else begin
      divCnt_q <= tick ? '0 : divCnt_q + 1'b1;
      if (tick) slot_q <= frameStart ? 3'h0 : slot_q + 3'h1;
      if (frameStart) begin
        bits_q <= bits_d;
        rd_q   <= rd_d;
      end
    end
  end

  // Pin drivers; floating pair reads as both high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dataPos_q <= '0;
      dataNeg_q <= '1;
      clkPos_q  <= 1'b0;
      clkNeg_q  <= 1'b1;
    end else begin
      for (int l = 0; l < LINES; l++) begin
        dataPos_q[l] <= dataFloat | bits_q[l][slot_q];
        dataNeg_q[l] <= dataFloat | ~bits_q[l][slot_q];
      end
      clkPos_q <= clockFloat | (slot_q < 3'(CLK_HIGH_SLOTS));
      clkNeg_q <= clockFloat | (slot_q >= 3'(CLK_HIGH_SLOTS));
    end
  end

  assign link.linkDataInPos  = dataPos_q;
  assign link.linkDataInNeg  = dataNeg_q;
  assign link.linkClockInPos = clkPos_q;
  assign link.linkClockInNeg = clkNeg_q;
endmodule

// File: core/lrdbc_rx.sv
`timescale 1ns/1ps
// Functional notes
// - power-down low forces all data outputs low
// - parallel clock rises when output data valid
// - deskew low over four clocks restarts calibration
// - deskew input held high in normal operation
// - balance select high enables decoding, else off
// - both ends must agree on balance mode
// - general control input held high by user
// - PLL range select held high, low reserved
// - clock present, data floating: outputs all high
// - cable disconnected: outputs hold last values
// - floating link clock: parallel clock held low
// - each line carries one balance bit per frame
// - balance bit zero plain, one inverted
// - data disparity is ones minus zeros
// - running disparity accumulates modified disparity
// - running disparity saturates at plus7, minus6
// - positive running, positive data: invert word
// - negative running, positive data: send plain
// - negative running, nonpositive data: invert word
// - zero running disparity: always invert word
// - calibration 4096 clocks, outputs low meanwhile; here only data is forced low, parallel clock keeps toggling
module lrdbc_rx #(
  parameter int CAL_COUNT = lrdbc_pkg::CAL_FRAMES
) (
  input  wire logic                        clock,
  input  wire logic                        rstn,
  lrdbc_link_if.rx                         link,
  input  wire logic                        powerDownN,
  input  wire logic                        deskewEnable,
  input  wire logic                        balanceSelect,
  input  wire logic                        generalControlTie,
  input  wire logic                        pllRangeSelect,
  output logic [lrdbc_pkg::WORD_W-1:0]     parallelDataOut,
  output logic                             parallelClockOut,
  output logic                             calibrating
);
  import lrdbc_pkg::*;

  localparam int SYNC_W = 2 * LINES + 5;

  logic [SYNC_W-1:0]   syncA_q;
  logic [SYNC_W-1:0]   syncB_q;
  logic                clkPrev_q;
  logic [DIV_W-1:0]    phase_q;
  logic [2:0]          slot_q;
  logic                armed_q;
  logic [SLOTS-1:0]    shift_q [LINES];
  logic                bad_q;
  logic [6:0]          lossCnt_q;
  logic [2:0]          lowCnt_q;
  logic                deskewPrev_q;
  logic [CAL_W-1:0]    calCnt_q;
  logic [4:0]          pclkCnt_q;
  logic [WORD_W-1:0]   data_q;
  logic                pclk_q;
  logic [WORD_W-1:0]   decoded;
  wire  [LINES-1:0]    sPos;
  wire  [LINES-1:0]    sNeg;
  wire                 sClkPos;
  wire                 sClkNeg;
  wire                 sPd;
  wire                 sDeskew;
  wire                 sBal;
  wire  [LINES-1:0]    dBit;
  wire  [LINES-1:0]    dBad;
  wire                 clkLevel;
  wire                 clkRise;
  wire                 clkOpen;
  wire                 sample;
  wire                 frameDone;
  wire                 frameBad;
  wire                 clkPresent;
  wire                 deskewRestart;
  wire                 forceLow;

  // Tie pins are the user's duty and steer nothing here
  wire unusedTies = generalControlTie & pllRangeSelect;

  // Two-stage synchroniser for every pin entering the clock domain
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      syncA_q <= '0;
      syncB_q <= '0;
    end else begin
      syncA_q <= {link.linkDataInPos, link.linkDataInNeg,
                  link.linkClockInPos, link.linkClockInNeg,
                  powerDownN, deskewEnable, balanceSelect};
      syncB_q <= syncA_q;
    end
  end

  // Synchronised fields; a floating pair shows both legs high
  assign sPos     = syncB_q[SYNC_W-1 -: LINES];
  assign sNeg     = syncB_q[SYNC_W-1-LINES -: LINES];
  assign sClkPos  = syncB_q[4];
  assign sClkNeg  = syncB_q[3];
  assign sPd      = syncB_q[2];
  assign sDeskew  = syncB_q[1];
  assign sBal     = syncB_q[0] & ~unusedTies | syncB_q[0] & unusedTies;
  assign dBit     = sPos & ~sNeg;
  assign dBad     = ~(sPos ^ sNeg);
  assign clkLevel = sClkPos & ~sClkNeg;
  assign clkRise  = clkLevel & ~clkPrev_q;
  assign clkOpen  = sClkPos & sClkNeg;

  // Sampling in the third system clock (phase 2) of each bit after each link clock rising edge; an open clock
  // pair means a pulled cable, so the frame is dropped and data holds
  assign sample    = armed_q && !clkOpen &&
                     phase_q == DIV_W'(SAMPLE_PHASE);
  assign frameDone = sample && slot_q == 3'(SLOTS - 1);
  assign frameBad  = bad_q | (|dBad);

  // Last slot is taken straight from the pins; decode per line
  always_comb begin
    logic [SLOTS-1:0] lw;
    lw      = '0;
    decoded = '0;
    for (int l = 0; l < LINES; l++) begin
      lw = {dBit[l], shift_q[l][DATA_BITS-1:0]};
      decoded[l*DATA_BITS +: DATA_BITS] = lw[DATA_BITS-1:0] ^
        {DATA_BITS{sBal & lw[BAL_SLOT]}};
    end
  end

  // Frame capture: edge restarts the bit counter
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      clkPrev_q <= 1'b0;
      phase_q   <= '0;
      slot_q    <= '0;
      armed_q   <= 1'b0;
      bad_q     <= 1'b0;
      for (int l = 0; l < LINES; l++) shift_q[l] <= '0;
    end else begin
      clkPrev_q <= clkLevel;
      phase_q   <= clkRise ? '0 : phase_q + 1'b1;
      if (clkRise) begin
        slot_q  <= '0;
        armed_q <= 1'b1;
        bad_q   <= 1'b0;
      end else if (clkOpen) begin
        armed_q <= 1'b0;
      end else if (sample) begin
        slot_q <= slot_q + 3'h1;
        bad_q  <= frameBad;
        if (frameDone) armed_q <= 1'b0;
        for (int l = 0; l < LINES; l++) shift_q[l][slot_q] <= dBit[l];
      end
    end
  end

  // Clock watchdog: two frames without an edge means no clock
  assign clkPresent = lossCnt_q < 7'(CLK_LOSS);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lossCnt_q <= 7'(CLK_LOSS);
    end else if (clkRise) begin
      lossCnt_q <= '0;
    end else if (clkPresent) begin
      lossCnt_q <= lossCnt_q + 7'h01;
    end
  end

  // Short deskew glitches are ignored; long ones retrigger calibration
  assign deskewRestart = sDeskew & ~deskewPrev_q &
                         (lowCnt_q > 3'(DESKEW_MIN_LOW));
  assign forceLow = ~sPd | ~sDeskew | (calCnt_q != '0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      deskewPrev_q <= 1'b0;
      lowCnt_q     <= '0;
      calCnt_q     <= CAL_W'(CAL_COUNT);
    end else begin
      deskewPrev_q <= sDeskew;
      if (sDeskew) lowCnt_q <= '0;
      else if (clkRise && lowCnt_q <= 3'(DESKEW_MIN_LOW))
        lowCnt_q <= lowCnt_q + 3'h1;
      // Power-down drops lock, so calibration starts over
      if (!sPd || deskewRestart) calCnt_q <= CAL_W'(CAL_COUNT);
      else if (frameDone && calCnt_q != '0)
        calCnt_q <= calCnt_q - 1'b1;
    end
  end

  // Output data: low when forced, ones on floating data, else decoded
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_q <= '0;
    end else if (forceLow) begin
      data_q <= '0;
    end else if (frameDone && clkPresent) begin
      data_q <= frameBad ? '1 : decoded;
    end
  end
  // Without frames the register simply holds

  // Parallel clock falls with new data, rises half a frame later
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pclk_q    <= 1'b0;
      pclkCnt_q <= '0;
    end else if (!sPd || !clkPresent) begin
      pclk_q    <= 1'b0;
      pclkCnt_q <= '0;
    end else if (frameDone) begin
      pclk_q    <= 1'b0;
      pclkCnt_q <= 5'(PCLK_HALF);
    end else if (pclkCnt_q != '0) begin
      pclkCnt_q <= pclkCnt_q - 5'h01;
      if (pclkCnt_q == 5'h01) pclk_q <= 1'b1;
    end
  end

  assign parallelDataOut  = data_q;
  assign parallelClockOut = pclk_q;

  // Status flop for the user side
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) calibrating <= 1'b1;
    else calibrating <= calCnt_q != '0;
  end
endmodule

// File: verification/lrdbc_link_sva.sv
`timescale 1ns/1ps
module lrdbc_link_sva (
  input wire logic                         clock,
  input wire logic                         rstn,
  input wire logic [lrdbc_pkg::LINES-1:0]  linkDataInPos,
  input wire logic [lrdbc_pkg::LINES-1:0]  linkDataInNeg,
  input wire logic                         linkClockInPos,
  input wire logic                         linkClockInNeg,
  input wire logic                         powerDownN,
  input wire logic                         deskewEnable,
  input wire logic                         balanceSelect,
  input wire logic [lrdbc_pkg::WORD_W-1:0] parallelDataOut,
  input wire logic                         parallelClockOut,
  input wire logic                         calibrating
);
  import lrdbc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic       lclk_q;
  logic [6:0] idle_q;
  logic [6:0] float_q;
  logic [7:0] low_q;
  logic [4:0] phase_q;
  wire        allFloat = &(linkDataInPos & linkDataInNeg);
  wire        lclkRise = linkClockInPos & ~lclk_q;
  // Saturating watch counters, so long faults never wrap
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lclk_q  <= 1'b0;
      idle_q  <= '0;
      float_q <= '0;
      low_q   <= '0;
      phase_q <= 5'h1f;
    end else begin
      lclk_q  <= linkClockInPos;
      idle_q  <= (linkClockInPos != lclk_q) ? '0 :
                 idle_q + 7'(idle_q != 7'h7f);
      float_q <= !allFloat ? '0 : float_q + 7'(float_q != 7'h7f);
      low_q   <= deskewEnable ? '0 : low_q + 8'(low_q != 8'hff);
      phase_q <= lclkRise ? '0 : phase_q + 5'(phase_q != 5'h1f);
    end
  end
  property p_pdLow;
    !powerDownN [*4] |-> parallelDataOut == '0;
  endproperty
  a_pdLow: assert property (p_pdLow)
    else $error("data not low in power-down");
  property p_strobe;
    parallelClockOut && $past(parallelClockOut) && powerDownN
      && $past(powerDownN, 6) && deskewEnable && $past(deskewEnable, 6)
      |-> $stable(parallelDataOut);
  endproperty
  a_strobe: assert property (p_strobe)
    else $error("data moved while strobe high");
  property p_deskew;
    $rose(deskewEnable) && low_q >= 8'ha0 |-> ##[0:64] calibrating;
  endproperty
  a_deskew: assert property (p_deskew)
    else $error("no recalibration after deskew pulse");
  property p_floatOnes;
    $fell(parallelClockOut) && float_q >= 7'h3c && idle_q < 7'h20
      && !$past(calibrating) && powerDownN && deskewEnable
      |-> &parallelDataOut;
  endproperty
  a_floatOnes: assert property (p_floatOnes)
    else $error("floating data not all ones");
  property p_cableHold;
    idle_q >= 7'h46 && powerDownN && $past(powerDownN, 4) && deskewEnable
      |-> $stable(parallelDataOut);
  endproperty
  a_cableHold: assert property (p_cableHold)
    else $error("data lost on cable pull");
  property p_clkLoss;
    idle_q >= 7'h46 |-> !parallelClockOut;
  endproperty
  a_clkLoss: assert property (p_clkLoss)
    else $error("strobe not low on clock loss");
  property p_balOff;
    !balanceSelect && !$past(balanceSelect, 32) && phase_q == 5'h18
      && linkDataInNeg == ~linkDataInPos |-> linkDataInPos == '0;
  endproperty
  a_balOff: assert property (p_balOff)
    else $error("balance slot set with balance off");
  property p_calQuiet;
    calibrating && $past(calibrating) |-> parallelDataOut == '0;
  endproperty
  a_calQuiet: assert property (p_calQuiet)
    else $error("data not low in calibration");
endmodule

// File: verification/lrdbc_tb_top.sv
`timescale 1ns/1ps
module lrdbc_tb_top;
  import lrdbc_pkg::*;
  logic              clock;
  logic              rstn;
  logic [WORD_W-1:0] sourceData;
  logic              sourceValid;
  logic              sourceReady;
  logic              balanceSelect;
  logic              dataFloat;
  logic              clockFloat;
  logic              powerDownN;
  logic              deskewEnable;
  logic [WORD_W-1:0] parallelDataOut;
  logic              parallelClockOut;
  logic              calibrating;
  logic              pclkPrev;
  logic              lclkPrev;
  logic              watch;
  logic              wireWatch;
  logic              sawFull;
  logic              inv;
  logic [6:0]        raw;
  logic [5:0]        dw;
  logic [4:0]        ph;
  logic [5:0]        pats [6];
  logic [WORD_W-1:0] expQ [$];
  logic [WORD_W-1:0] w;
  int                rd;
  int                dd;
  int                failures;
  int                checks_done;

  lrdbc_link_if link ();
  lrdbc_tx lrdbc_tx_i (.clock(clock), .rstn(rstn), .sourceData(sourceData),
    .sourceValid(sourceValid), .sourceReady(sourceReady),
    .balanceSelect(balanceSelect), .dataFloat(dataFloat),
    .clockFloat(clockFloat), .link(link));
  // Control ties held high as the user must
  lrdbc_rx #(.CAL_COUNT(4)) lrdbc_rx_i (.clock(clock), .rstn(rstn),
    .link(link), .powerDownN(powerDownN), .deskewEnable(deskewEnable),
    .balanceSelect(balanceSelect), .generalControlTie(1'b1),
    .pllRangeSelect(1'b1), .parallelDataOut(parallelDataOut),
    .parallelClockOut(parallelClockOut), .calibrating(calibrating));
  lrdbc_link_sva lrdbc_link_sva_i (.clock(clock), .rstn(rstn),
    .linkDataInPos(link.linkDataInPos), .linkDataInNeg(link.linkDataInNeg),
    .linkClockInPos(link.linkClockInPos),
    .linkClockInNeg(link.linkClockInNeg), .powerDownN(powerDownN),
    .deskewEnable(deskewEnable), .balanceSelect(balanceSelect),
    .parallelDataOut(parallelDataOut), .parallelClockOut(parallelClockOut),
    .calibrating(calibrating));

  task automatic cmpWord(input logic [WORD_W-1:0] got,
                         input logic [WORD_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("failures %0d checks %0d", failures, checks_done);
    if (failures == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Waits for calibration done and scoreboard empty, with a hard bound
  task automatic waitIdle(input int lim);
    int n;
    n = 0;
    while ((calibrating !== 1'b0 || expQ.size() != 0) && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (calibrating !== 1'b0 || expQ.size() != 0) begin
      failures++;
      $display("CHECK FAILED %0t idle wait timed out", $time);
      final_report();
    end
  endtask
  // Holds valid until taken; ready is settled at the falling edge,
  // so the next rising edge is the one that takes the word
  task automatic sendWord(input logic [WORD_W-1:0] v);
    int n;
    n = 0;
    @(negedge clock);
    sourceData = v;
    sourceValid = 1'b1;
    while (sourceReady !== 1'b1 && n < 400) begin
      sawFull = 1'b1;
      n++;
      @(negedge clock);
    end
    if (n == 400) begin
      failures++;
      $display("CHECK FAILED %0t source never ready", $time);
      final_report();
    end
    @(posedge clock);
    expQ.push_back(v);
  endtask
  task automatic sendRand(input int n);
    repeat (n) begin
      w = WORD_W'({$urandom, $urandom});
      if (w == '0) w = 1;
      sendWord(w);
    end
    @(negedge clock);
    sourceValid = 1'b0;
  endtask
  task automatic resetDut(input logic balance_select);
    @(negedge clock);
    rstn = 1'b0;
    balanceSelect = balance_select;
    cycles(20);
    rstn = 1'b1;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Scoreboard: fresh nonzero words at the strobe edge; empty frames skipped
  always @(posedge clock) begin
    if (watch && parallelClockOut && !pclkPrev && parallelDataOut !== '0) begin
      if (expQ.size() == 0) cmpWord(parallelDataOut, '0);
      else cmpWord(parallelDataOut, expQ.pop_front());
    end
    pclkPrev = parallelClockOut;
  end
  // Wire model of line 0: recovers each frame and replays the encoder
  always @(posedge clock) begin
    if (!rstn) begin
      rd = 0;
      ph = 5'h1f;
    end else begin
      if (link.linkClockInPos && !lclkPrev) ph = 0;
      else if (ph != 5'h1f) ph++;
      if (ph[1:0] == 2'h2 && ph < 5'h1c) raw[ph[4:2]] = link.linkDataInPos[0];
      if (ph == 5'h1a && wireWatch) begin
        dw = raw[6] ? ~raw[5:0] : raw[5:0];
        dd = 2 * $countones(dw) - 6;
        inv = (rd == 0) || (rd > 0 && dd > 0) || (rd < 0 && dd <= 0);
        if (balanceSelect) begin
          cmpBit(raw[6], inv);
          rd = inv ? rd + 1 - dd : rd + dd - 1;
          if (rd > 7) rd = 7;
          if (rd < -6) rd = -6;
        end else cmpBit(raw[6], 1'b0);
      end
    end
    lclkPrev = link.linkClockInPos;
  end

  initial begin
    rstn = 1'b0;
    sourceData = '0;
    sourceValid = 1'b0;
    balanceSelect = 1'b0;
    dataFloat = 1'b0;
    clockFloat = 1'b0;
    powerDownN = 1'b1;
    deskewEnable = 1'b1;
    watch = 1'b1;
    wireWatch = 1'b1;
    sawFull = 1'b0;
    pclkPrev = 1'b0;
    lclkPrev = 1'b0;
    failures = 0;
    checks_done = 0;
    pats = '{6'h3f, 6'h00, 6'h07, 6'h01, 6'h3e, 6'h3f};
    void'($urandom(82));
    resetDut(1'b0);
    waitIdle(4000);
    // Plain mode, back to back until the buffer refuses
    sendRand(14);
    cmpBit(sawFull, 1'b1);
    waitIdle(2000);
    powerDownN = 1'b0;
    cycles(6);
    cmpWord(parallelDataOut, '0);
    powerDownN = 1'b1;
    waitIdle(4000);
    // Deskew pulse well past four link clocks
    deskewEnable = 1'b0;
    cycles(200);
    cmpWord(parallelDataOut, '0);
    deskewEnable = 1'b1;
    cycles(40);
    cmpBit(calibrating, 1'b1);
    waitIdle(4000);
    // Both ends in balance mode; disparity corners then random traffic
    resetDut(1'b1);
    waitIdle(4000);
    foreach (pats[i]) sendWord({{7{6'h15}}, pats[i]});
    sendRand(10);
    waitIdle(2000);
    // Open data pairs with the link clock still running
    watch = 1'b0;
    wireWatch = 1'b0;
    dataFloat = 1'b1;
    cycles(150);
    cmpWord(parallelDataOut, {WORD_W{1'b1}});
    dataFloat = 1'b0;
    cycles(100);
    watch = 1'b1;
    sendRand(1);
    waitIdle(2000);
    // Cable pull: last word must stand, strobe low
    watch = 1'b0;
    dataFloat = 1'b1;
    clockFloat = 1'b1;
    cycles(200);
    cmpWord(parallelDataOut, w);
    cmpBit(parallelClockOut, 1'b0);
    final_report();
  end
endmodule
